// File: verilog/ssp_spi_port.sv
// serial port in spi mode: control, status, data buffer and shifter
// software side is plain strobes; pins arrive unsynchronised
//
// Overview of operation
// R1 - complete received byte moves to the data buffer and sets the done flag
// R2 - data buffer write loads buffer and shift register together
// R3 - status bits 5:0 read only, bits 7:6 read and write
// R4 - control register one fully readable and writable
// R5 - configuration is control one bits 5:0 plus status bits 7:6
// R6 - master drives sck from its own generated clock
// R7 - slave takes sck as input from the external master
// R8 - clock polarity sets the idle level of sck
// R9 - sample phase picks middle or end of data output time; a slave ignores it and always samples mid bit
// R10 - clock edge picks which sck edge changes output data
// R11 - rate selection matters only in master mode
// R12 - slave select option gates slave transfers only
// R13 - port stays inactive while port enable is clear
// R14 - software clears enable, rewrites controls, then sets enable
// R15 - port enable hands sdi, sdo, sck and ss pins to the port
// R16 - software sets the sdi direction bit to make it an input
// R17 - software clears the sdo direction bit so it is driven
// R18 - sck direction cleared as master, set as slave; ss set
// R19 - a direction bit of opposite value suppresses that pin function; the sdi direction bit is not used, sdi is always sampled
// R20 - rate reload register sets the generator in one master mode
// R21 - shift register reachable only through the data buffer
// R22 - eight bits per transfer, msb first, one bit each way per sck cycle
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module ssp_spi_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ctrl1_wr,
	input wire logic [7:0] ctrl1_wdata,
	input wire logic stat_wr,
	input wire logic [7:0] stat_wdata,
	input wire logic reload_wr,
	input wire logic [7:0] reload_wdata,
	input wire logic dbuf_wr,
	input wire logic [7:0] dbuf_wdata,
	input wire logic dbuf_rd,
	input wire logic done_clr,
	input wire logic dir_sdi,
	input wire logic dir_sdo,
	input wire logic dir_sck,
	input wire logic dir_ss,
	input wire logic sck_in,
	input wire logic sdi_in,
	input wire logic ss_n_in,
	output logic [7:0] ctrl1_rdata,
	output logic [7:0] stat_rdata,
	output logic [7:0] reload_rdata,
	output logic [7:0] dbuf_rdata,
	output logic spi_done_flag,
	output logic sck_out,
	output logic sck_oe,
	output logic sdo_out,
	output logic sdo_oe
);
	ssp_pkg::ssp_core_s s_r;
	ssp_pkg::ssp_core_s s_nxt;
	logic en;
	logic [3:0] mode;
	logic master;
	logic ckp;
	logic cke;
	logic smp_eff;
	logic ss_ok;
	logic ev;
	logic [4:0] k;
	logic odd;
	logic last;
	logic shift_now;
	logic samp_now;
	logic bit_in;
	logic busy;
	logic [7:0] shifted;
	logic [`SSP_HALF_W-1:0] half;
	logic rate_tick;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [7:0] fifo_out_data;

	// decoded configuration
	assign en = s_r.ctrl1[`SSP_C1_EN];
	assign mode = s_r.ctrl1[`SSP_C1_MODE_HI:`SSP_C1_MODE_LO];
	assign master = (mode != `SSP_MODE_S_SS) && (mode != `SSP_MODE_S_NOSS); // R5
	assign ckp = s_r.ctrl1[`SSP_C1_CKP];
	assign cke = s_r.stat_hi[0];
	// slaves always sample mid bit; end sampling needs a master's timing
	assign smp_eff = master & s_r.stat_hi[1]; // R9
	// ss only gates with ss enabled; if the pin is not an input the slave is never selected
	assign ss_ok = (mode != `SSP_MODE_S_SS) || (!s_r.ss_sy[1] && dir_ss); // R12 R19

	// master half period; the rate choice is ignored in slave roles
	always_comb begin
		case (mode)
			`SSP_MODE_M_DIV16: half = `SSP_HALF_DIV16;
			`SSP_MODE_M_DIV64: half = `SSP_HALF_DIV64;
			// reload value sets sck to clk / (4 * (reload + 1))
			`SSP_MODE_M_RELOAD: half = {1'b0, s_r.reload, 1'b0} + `SSP_HALF_DIV4; // R20
			default: half = `SSP_HALF_DIV4;
		endcase
	end

	ssp_rate_gen u_rate (
		.clk(clk),
		.rst_n(rst_n),
		.run(en && master && (s_r.phase == ssp_pkg::SSP_PH_SHIFT)), // R11
		.half(half),
		.tick(rate_tick)
	);

	// clock edge events: own ticks as master, synced sck changes as slave
	assign ev = master ? rate_tick : // R6
		(en && dir_sck && ss_ok && (s_r.sck_sy[1] != s_r.sck_prev)); // R7 R19
	assign k = s_r.edges + 5'h01;
	assign odd = k[0];
	assign last = (k == `SSP_EDGES_PER_BYTE);
	// edge placement of shifting and sampling per clock edge and phase
	// k counts the sck edges of one byte, 1 to 16:
	//   clock edge set, sample mid: sample on odd k, shift on even k
	//   clock edge set, sample end: sample and shift together on even k
	//   clock edge clear, sample mid: sample on even k, shift on odd k from 3 and on k 16
	//   clock edge clear, sample end: sample with every shift
	// the first leading edge never shifts because the msb already sits on sdo
	// the shift on k 16 pulls the last sampled bit into the finished byte
	// a slave only samples mid bit: sdi reaches it two clocks late through the
	// synchroniser, so end sampling would catch the partner's next bit instead
	assign shift_now = cke ? !odd : ((odd && (k != 5'h01)) || last); // R10
	assign samp_now = cke ? (smp_eff ? !odd : odd) :
		(smp_eff ? ((odd && (k != 5'h01)) || last) : !odd); // R9
	assign bit_in = samp_now ? s_r.sdi_sy[1] : s_r.samp;
	assign shifted = {s_r.shreg[6:0], bit_in}; // R22
	assign busy = s_r.pend || (s_r.phase == ssp_pkg::SSP_PH_SHIFT) || (s_r.edges != 5'h00);
	assign fifo_out_ready = en && !s_r.bf;

	ssp_rx_fifo u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.flush(!en),
		.in_valid(s_r.push),
		.in_data(s_r.push_data),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// whole next state of the port
	always_comb begin
		s_nxt = s_r;
		s_nxt.push = 1'b0;
		// pin synchronisers; stage 0 feeds stage 1 only
		s_nxt.sck_sy = {s_r.sck_sy[0], sck_in};
		s_nxt.sdi_sy = {s_r.sdi_sy[0], sdi_in};
		s_nxt.ss_sy = {s_r.ss_sy[0], ss_n_in};
		s_nxt.sck_prev = s_r.sck_sy[1];
		// software writes
		if (ctrl1_wr) begin
			s_nxt.ctrl1 = ctrl1_wdata; // R4 R14
		end
		if (stat_wr) begin
			s_nxt.stat_hi = stat_wdata[`SSP_ST_SMP:`SSP_ST_CKE]; // R3
		end
		if (reload_wr) begin
			s_nxt.reload = reload_wdata;
		end
		// write goes to buffer and shifter at once; a write while busy collides
		if (dbuf_wr && en) begin
			if (busy) begin
				s_nxt.ctrl1[`SSP_C1_WCOL] = 1'b1;
			end else begin
				s_nxt.dbuf = dbuf_wdata; // R2 R21
				s_nxt.shreg = dbuf_wdata; // R2
				s_nxt.pend = master;
			end
		end
		// master waits for buffer room so a finished byte is never dropped
		if (s_r.pend && fifo_in_ready && !s_r.push) begin
			s_nxt.pend = 1'b0;
			s_nxt.phase = ssp_pkg::SSP_PH_SHIFT;
		end
		// slave with ss gating: a raised ss aborts the partial byte
		if (!master && !ss_ok) begin
			s_nxt.edges = 5'h00;
		end
		if (ev) begin
			if (samp_now) begin
				s_nxt.samp = s_r.sdi_sy[1];
			end
			if (shift_now) begin
				s_nxt.shreg = shifted; // R22
			end
			if (master) begin
				s_nxt.sck_out = ~s_r.sck_out; // R6
			end
			s_nxt.edges = k;
			if (!master) begin
				s_nxt.phase = ssp_pkg::SSP_PH_SHIFT;
			end
			// byte complete: hand it to the receive buffer, raise the flag
			if (last) begin
				s_nxt.edges = 5'h00;
				s_nxt.phase = ssp_pkg::SSP_PH_IDLE;
				s_nxt.push = 1'b1; // R1
				s_nxt.push_data = shifted; // R1
			end
		end
		// a slave byte arriving with the buffer full is lost and flagged
		if (s_r.push && !fifo_in_ready) begin
			s_nxt.ctrl1[`SSP_C1_OVF] = 1'b1;
		end
		// buffer readout; a read frees the buffer for the next byte
		if (dbuf_rd) begin
			s_nxt.bf = 1'b0;
		end
		if (fifo_out_valid && fifo_out_ready) begin
			s_nxt.dbuf = fifo_out_data; // R1
			s_nxt.bf = 1'b1; // R1
		end
		// done flag: a new byte wins over a clear in the same cycle
		if (done_clr) begin
			s_nxt.done = 1'b0;
		end
		if (s_r.push && fifo_in_ready) begin
			s_nxt.done = 1'b1; // R1
		end
		// idle sck level follows polarity while no transfer runs
		if (s_nxt.phase == ssp_pkg::SSP_PH_IDLE || !master) begin
			s_nxt.sck_out = s_nxt.ctrl1[`SSP_C1_CKP]; // R8
		end
		// disabled port holds the engine in reset
		if (!s_nxt.ctrl1[`SSP_C1_EN]) begin
			s_nxt.edges = 5'h00; // R13
			s_nxt.phase = ssp_pkg::SSP_PH_IDLE; // R13
			s_nxt.pend = 1'b0;
			s_nxt.bf = 1'b0;
			s_nxt.samp = 1'b0;
		end
		// pin ownership: enable claims the pins, direction bits veto drive
		s_nxt.sdo = s_nxt.shreg[7]; // R22
		s_nxt.sck_oe = s_nxt.ctrl1[`SSP_C1_EN] && master && !dir_sck; // R15 R19
		s_nxt.sdo_oe = s_nxt.ctrl1[`SSP_C1_EN] && !dir_sdo && (master || ss_ok); // R15 R19
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.ctrl1 <= `SSP_C1_RESET;
			s_r.stat_hi <= `SSP_ST_RESET;
			s_r.reload <= `SSP_RELOAD_RESET;
			s_r.dbuf <= `SSP_DBUF_RESET;
			s_r.phase <= ssp_pkg::SSP_PH_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// readback: status low bits only show hardware state
	assign ctrl1_rdata = s_r.ctrl1; // R4
	assign stat_rdata = {s_r.stat_hi, 5'h00, s_r.bf}; // R3
	assign reload_rdata = s_r.reload;
	assign dbuf_rdata = s_r.dbuf; // R21
	assign spi_done_flag = s_r.done;
	assign sck_out = s_r.sck_out;
	assign sck_oe = s_r.sck_oe;
	assign sdo_out = s_r.sdo;
	assign sdo_oe = s_r.sdo_oe;
endmodule : ssp_spi_port
`default_nettype wire

// File: verilog/ssp_params.svh
// bit positions, reset values and divider counts of the serial port
// included by the port, package and rate generator files; definitions only
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// control register one fields
`define SSP_C1_WCOL 7
`define SSP_C1_OVF 6
`define SSP_C1_EN 5
`define SSP_C1_CKP 4
`define SSP_C1_MODE_HI 3
`define SSP_C1_MODE_LO 0
// status register fields
`define SSP_ST_SMP 7
`define SSP_ST_CKE 6
`define SSP_ST_BF 0
// reset values
`define SSP_C1_RESET 8'h00
`define SSP_ST_RESET 2'h0
`define SSP_RELOAD_RESET 8'h00
`define SSP_DBUF_RESET 8'h00
// role and rate encodings of control register one bits 3:0
`define SSP_MODE_M_DIV4 4'h0
`define SSP_MODE_M_DIV16 4'h1
`define SSP_MODE_M_DIV64 4'h2
`define SSP_MODE_S_SS 4'h4
`define SSP_MODE_S_NOSS 4'h5
`define SSP_MODE_M_RELOAD 4'hA
// half periods of the master clock in system clocks
`define SSP_HALF_W 10
`define SSP_HALF_DIV4 10'h002
`define SSP_HALF_DIV16 10'h008
`define SSP_HALF_DIV64 10'h020
// clock edges in one byte transfer
`define SSP_EDGES_PER_BYTE 5'h10
`endif

// File: verilog/ssp_pkg.sv
// types shared by the serial port modules
// needs ssp_params.svh on the include path
`default_nettype none
`include "ssp_params.svh"
package ssp_pkg;
	typedef enum logic {SSP_PH_IDLE, SSP_PH_SHIFT} ssp_phase_e;

	// rate generator state
	typedef struct packed {
		logic [`SSP_HALF_W-1:0] cnt;
		logic tick;
	} ssp_rate_s;

	// two-entry receive buffer state
	typedef struct packed {
		logic [1:0][7:0] mem;
		logic wr;
		logic rd;
		logic [1:0] cnt;
	} ssp_fifo_s;

	// serial port core state
	typedef struct packed {
		logic [7:0] ctrl1;
		logic [1:0] stat_hi;
		logic [7:0] reload;
		logic [7:0] dbuf;
		logic bf;
		logic [7:0] shreg;
		logic samp;
		logic [4:0] edges;
		ssp_phase_e phase;
		logic pend;
		logic done;
		logic push;
		logic [7:0] push_data;
		logic [1:0] sck_sy;
		logic [1:0] sdi_sy;
		logic [1:0] ss_sy;
		logic sck_prev;
		logic sck_out;
		logic sck_oe;
		logic sdo;
		logic sdo_oe;
	} ssp_core_s;
endpackage : ssp_pkg
`default_nettype wire

// File: verilog/ssp_rate_gen.sv
// master clock rate generator: one tick every half period
// half is held steady by the caller while run is high
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module ssp_rate_gen (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [`SSP_HALF_W-1:0] half,
	output logic tick
);
	ssp_pkg::ssp_rate_s s_r;
	ssp_pkg::ssp_rate_s s_nxt;

	// count to half, tick registered so it lines up with the count wrap
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (!run) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt >= half - `SSP_HALF_W'(1)) begin
			s_nxt.cnt = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + `SSP_HALF_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;
endmodule : ssp_rate_gen
`default_nettype wire

// File: verilog/ssp_rx_fifo.sv
// two-entry receive buffer between the shifter and the data buffer
// writer must hold off while in_ready is low; flush empties it
`timescale 1ns/1ps
`default_nettype none
module ssp_rx_fifo (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	output logic in_ready,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data
);
	ssp_pkg::ssp_fifo_s s_r;
	ssp_pkg::ssp_fifo_s s_nxt;
	logic do_wr;
	logic do_rd;

	assign in_ready = (s_r.cnt != 2'h2);
	assign out_valid = (s_r.cnt != 2'h0);
	assign out_data = s_r.mem[s_r.rd];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	// pointer and count update; simultaneous push and pop keeps count
	always_comb begin
		s_nxt = s_r;
		if (do_wr) begin
			s_nxt.mem[s_r.wr] = in_data;
			s_nxt.wr = ~s_r.wr;
		end
		if (do_rd) begin
			s_nxt.rd = ~s_r.rd;
		end
		if (do_wr && !do_rd) begin
			s_nxt.cnt = s_r.cnt + 2'h1;
		end else if (do_rd && !do_wr) begin
			s_nxt.cnt = s_r.cnt - 2'h1;
		end
		if (flush) begin
			s_nxt.wr = 1'b0;
			s_nxt.rd = 1'b0;
			s_nxt.cnt = 2'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : ssp_rx_fifo
`default_nettype wire

// File: testbench/ssp_slave_model.sv
// external spi device at the far end of the link: shifts tx out, collects rx
// assumes sck idles low and data changes on falling sck, whichever side clocks
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_model (
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_n,
	input wire logic slow,
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	logic [7:0] sh;
	// a slow slave answers late but still within half a bit
	always @(negedge sel_n) begin
		sh = tx;
		miso <= #(slow ? 30 : 1) tx[7];
	end
	always @(posedge sck) if (!sel_n) rx = {rx[6:0], mosi};
	always @(negedge sck) if (!sel_n) begin
		sh = {sh[6:0], 1'b0};
		miso <= #(slow ? 30 : 1) sh[7];
	end
	// released line shows no stale data
	always @(posedge sel_n) miso <= ~miso;
	initial miso = 1'b0;
endmodule : ssp_slave_model
`default_nettype wire

// File: testbench/ssp_spi_port_assertions.sv
// port checker for the spi port; sees only its ports
// bound from the bench top; one clock, reset async active low
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_port_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ctrl1_wr,
	input wire logic [7:0] ctrl1_wdata,
	input wire logic stat_wr,
	input wire logic [7:0] stat_wdata,
	input wire logic reload_wr,
	input wire logic [7:0] reload_wdata,
	input wire logic dbuf_wr,
	input wire logic dir_sdo,
	input wire logic [7:0] ctrl1_rdata,
	input wire logic [7:0] stat_rdata,
	input wire logic [7:0] reload_rdata,
	input wire logic spi_done_flag,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic sdo_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic on;
	assign on = ctrl1_rdata[5];
	// a master clock edge at clk/16 must then hold for a full half period
	sequence s_edge;
		on && ctrl1_rdata[3:0] == 4'h1 && $changed(sck_out);
	endsequence
	property p_half;
		s_edge |=> (!on || $stable(sck_out)) [*7];
	endproperty
	a_half: assert property (p_half) else $error("sck half period short");
	property p_c1;
		ctrl1_wr && !dbuf_wr |=> ctrl1_rdata[5:0] == $past(ctrl1_wdata[5:0]);
	endproperty
	a_c1: assert property (p_c1) else $error("control one readback wrong");
	property p_st;
		stat_wr |=> stat_rdata[7:6] == $past(stat_wdata[7:6]);
	endproperty
	a_st: assert property (p_st) else $error("status high bits wrong");
	property p_ro;
		stat_rdata[5:1] == 5'h00;
	endproperty
	a_ro: assert property (p_ro) else $error("status low bits not zero");
	property p_rl;
		reload_wr |=> reload_rdata == $past(reload_wdata);
	endproperty
	a_rl: assert property (p_rl) else $error("reload readback wrong");
	property p_off;
		!on && !$past(on) |-> !sck_oe && !sdo_oe;
	endproperty
	a_off: assert property (p_off) else $error("pins driven while off");
	property p_veto;
		dir_sdo && $past(dir_sdo) |-> !sdo_oe;
	endproperty
	a_veto: assert property (p_veto) else $error("sdo driven against dir");
	property p_idle;
		$rose(on) && ctrl1_rdata[3:0] == 4'h0 |-> ##1 sck_out == ctrl1_rdata[4];
	endproperty
	a_idle: assert property (p_idle) else $error("sck idle level wrong");
	property p_done;
		$rose(spi_done_flag) |-> ##[0:2] stat_rdata[0];
	endproperty
	a_done: assert property (p_done) else $error("buffer full not set");
endmodule : ssp_spi_port_chk
`default_nettype wire

// File: testbench/ssp_spi_port_tb_top.sv
// bench top: spi port as master or slave facing a shift partner model
// inputs change 2 ns after the rising edge; checker bound below
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_port_tb_top;
	logic clk, rst_n, ctrl1_wr, stat_wr, reload_wr, dbuf_wr, dbuf_rd, done_clr;
	logic [7:0] ctrl1_wdata, stat_wdata, reload_wdata, dbuf_wdata, d, s_tx, s_rx, lfsr;
	logic dir_sdi, dir_sdo, dir_sck, dir_ss, sdi_in, sel_n, slow, slv, tsck, lsck;
	logic [7:0] ctrl1_rdata, stat_rdata, reload_rdata, dbuf_rdata;
	logic spi_done_flag, sck_out, sck_oe, sdo_out, sdo_oe;
	logic [15:0] e;
	logic [15:0] expq [$];
	int n_fail, checks, k;
	// link clock: the port's own sck, or the bench's while the port is a slave
	assign lsck = slv ? tsck : sck_out;
	ssp_spi_port ssp_spi_port_i (.clk, .rst_n, .ctrl1_wr, .ctrl1_wdata, .stat_wr,
		.stat_wdata, .reload_wr, .reload_wdata, .dbuf_wr, .dbuf_wdata, .dbuf_rd,
		.done_clr, .dir_sdi, .dir_sdo, .dir_sck, .dir_ss, .sck_in(lsck), .sdi_in,
		.ss_n_in(sel_n), .ctrl1_rdata, .stat_rdata, .reload_rdata, .dbuf_rdata,
		.spi_done_flag, .sck_out, .sck_oe, .sdo_out, .sdo_oe);
	ssp_slave_model ssp_slave_model_i (.sck(lsck), .mosi(sdo_out), .sel_n, .slow,
		.tx(s_tx), .miso(sdi_in), .rx(s_rx));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic give_verdict();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] s);
		checks++;
		if (s !== x) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, s);
		end
	endtask : chk
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction : rnd
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cyc
	// strobe 0 control one, 1 status, 2 reload, 3 data buffer; gap keeps strobes apart
	task automatic wr(input int r, input logic [7:0] v);
		{ctrl1_wdata, stat_wdata, reload_wdata, dbuf_wdata} = {4{v}};
		{ctrl1_wr, stat_wr, reload_wr, dbuf_wr} = 4'h8 >> r;
		cyc(1);
		{ctrl1_wr, stat_wr, reload_wr, dbuf_wr} = 4'h0;
		cyc(1);
	endtask : wr
	// one byte each way; dup also tries a write while busy
	task automatic xfer(input logic [7:0] m, input logic [7:0] s, input logic dup);
		s_tx = s;
		sel_n = 1'b0;
		cyc(1);
		expq.push_back({s, m});
		wr(3, m);
		if (dup) wr(3, ~m);
		// facing a slave-role port the bench makes sck itself, well below clk/8
		for (int j = 0; j < 16 && slv; j++) begin
			cyc(8);
			tsck = ~tsck;
		end
		for (k = 0; k < 3000 && expq.size() != 0; k++) cyc(1);
		if (k == 3000) begin
			n_fail++;
			give_verdict();
		end
		if (dup) chk("collision", 8'h80, ctrl1_rdata & 8'h80);
		sel_n = 1'b1;
		cyc(1);
	endtask : xfer
	// result watcher: oldest note checked when a byte lands
	initial forever begin
		@(posedge clk iff spi_done_flag === 1'b1);
		cyc(1);
		if (expq.size() == 0) begin
			n_fail++;
			$display("CHECK FAILED rx note expected 1 seen 0");
			e = 16'h0000;
		end else begin
			e = expq[0];
		end
		chk("rx byte", e[15:8], dbuf_rdata);
		chk("full", 8'h01, stat_rdata & 8'h01);
		chk("slave rx", e[7:0], s_rx);
		{done_clr, dbuf_rd} = 2'b11;
		cyc(1);
		{done_clr, dbuf_rd} = 2'b00;
		if (expq.size() != 0) void'(expq.pop_front());
	end
	initial begin
		{ctrl1_wr, stat_wr, reload_wr, dbuf_wr, dbuf_rd, done_clr} = 6'h00;
		{ctrl1_wdata, stat_wdata, reload_wdata, dbuf_wdata, s_tx} = 40'h0;
		{dir_sdi, dir_sdo, dir_sck, dir_ss} = 4'b1001;
		{sel_n, slow, slv, tsck} = 4'h8;
		n_fail = 0;
		checks = 0;
		lfsr = 8'h18;
		rst_n = 1'b0;
		cyc(5);
		rst_n = 1'b1;
		wr(1, 8'hFF);
		chk("status", 8'hC0, stat_rdata);
		for (int i = 0; i < 4; i++) begin
			d = rnd() & 8'hDF;
			wr(2, d);
			chk("reload", d, reload_rdata);
			wr(0, d);
			chk("control one", d, ctrl1_rdata);
		end
		wr(3, 8'hA5);
		cyc(40);
		chk("off", 8'h00, {6'h00, sck_oe, spi_done_flag});
		chk("off buffer", 8'h00, dbuf_rdata);
		wr(0, 8'h01);
		wr(1, 8'h40);
		wr(0, 8'h21);
		chk("pins", 8'h06, {5'h00, sck_oe, sdo_oe, sck_out});
		for (int i = 0; i < 4; i++) begin
			slow = i[0];
			xfer(rnd(), rnd(), 1'b0);
		end
		wr(0, 8'h02);
		wr(0, 8'h22);
		xfer(rnd(), rnd(), 1'b0);
		wr(0, 8'h01);
		wr(2, 8'h01);
		wr(0, 8'h2A);
		xfer(rnd(), rnd(), 1'b1);
		xfer(8'h80, 8'h01, 1'b0);
		wr(0, 8'h0A);
		wr(1, 8'hC0);
		wr(0, 8'h2A);
		xfer(rnd(), rnd(), 1'b0);
		wr(0, 8'h04);
		dir_sck = 1'b1;
		slv = 1'b1;
		wr(0, 8'h24);
		chk("slave ss high", 8'h00, {6'h00, sck_oe, sdo_oe});
		xfer(rnd(), rnd(), 1'b0);
		wr(0, 8'h05);
		wr(0, 8'h25);
		xfer(rnd(), rnd(), 1'b0);
		slv = 1'b0;
		dir_sck = 1'b0;
		wr(0, 8'h01);
		wr(0, 8'h30);
		chk("idle high", 8'h01, {7'h00, sck_out});
		{dir_sck, dir_sdo} = 2'b11;
		cyc(2);
		chk("veto", 8'h00, {6'h00, sck_oe, sdo_oe});
		give_verdict();
	end
endmodule : ssp_spi_port_tb_top
bind ssp_spi_port ssp_spi_port_chk ssp_spi_port_chk_i (.clk, .rst_n, .ctrl1_wr,
	.ctrl1_wdata, .stat_wr, .stat_wdata, .reload_wr, .reload_wdata, .dbuf_wr,
	.dir_sdo, .ctrl1_rdata, .stat_rdata, .reload_rdata, .spi_done_flag, .sck_out,
	.sck_oe, .sdo_oe);
`default_nettype wire
